// ---- dbgwr_core.v ----
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "dbgwr_consts.vh"

module dbgwr_core (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        rx_valid,
    input  wire [7:0]  rx_byte,
    output wire        rx_ready,
    output reg         tx_valid,
    output reg  [7:0]  tx_byte,
    input  wire        tx_ready,
    output reg         ack_pulse,
    input  wire        sync_pulse,
    output reg         soft_reset,
    input  wire        cpu_halted,
    input  wire        cpu_in_wait,
    input  wire        cpu_in_stop,
    input  wire        external_stall_input,
    input  wire [23:0] cpu_pc_current,
    input  wire [23:0] cpu_pc_next,
    output reg         mem_req,
    output reg  [23:0] mem_addr,
    output reg  [31:0] mem_wdata,
    output reg  [1:0]  mem_size,
    input  wire        mem_done,
    input  wire        mem_abort,
    output reg         reg_wr,
    output reg  [3:0]  reg_sel,
    output reg  [31:0] reg_wdata,
    input  wire        reg_done,
    output reg         step_req,
    input  wire        step_done,
    output reg         flash_erase_req,
    input  wire        flash_erase_done
);

    localparam ST_IDLE  = 4'd0;
    localparam ST_ADDR  = 4'd1;
    localparam ST_DATA  = 4'd2;
    localparam ST_MEMW  = 4'd3;
    localparam ST_STAT  = 4'd4;
    localparam ST_RDATA = 4'd5;
    localparam ST_REGW  = 4'd6;
    localparam ST_PCTX  = 4'd7;
    localparam ST_CSRD  = 4'd8;
    localparam ST_STEPW = 4'd9;

    reg  [3:0]  state;
    reg  [2:0]  cnt;
    reg  [31:0] shreg;
    reg  [23:0] pc_tx;
    reg  [23:0] pc_last;
    reg         with_status;
    reg  [15:0] csr;
    reg  [7:0]  div_cnt;
    reg         wipe_armed;
    reg  [9:0]  wipe_timer;

    wire        dsc_tick = (div_cnt == `DBGWR_DSC_DIV - 8'd1);
    wire        rx_take  = rx_valid && rx_ready;
    wire        tx_free  = !tx_valid || tx_ready;
    wire        ack_en   = csr[`DBGWR_CSR_ACKEN];
    wire        apb_wr   = psel && penable && pwrite;
    wire        apb_map  = (paddr == `DBGWR_ADDR_CSR) || (paddr == `DBGWR_ADDR_PC);
    wire [31:0] next_shreg = {shreg[23:0], rx_byte};

    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !apb_map;
    assign rx_ready = (state == ST_IDLE) || (state == ST_ADDR) || (state == ST_DATA) ||
                      (state == ST_RDATA) || (state == ST_CSRD);

    // bytes of payload per store size
    function [2:0] size_bytes;
        input [1:0] sz;
        begin
            case (sz)
                2'd0:    size_bytes = 3'd1;
                2'd1:    size_bytes = 3'd2;
                default: size_bytes = 3'd4;
            endcase
        end
    endfunction

    // command-side flag events, merged with clears below
    reg set_no_response_flag;
    reg set_illegal_access_flag;
    reg set_illegal_command_flag;
    reg set_wipe;
    reg csr_cmd_wr;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 8'd0;
        end else if (dsc_tick) begin
            div_cnt <= 8'd0;
        end else begin
            div_cnt <= div_cnt + 8'd1;
        end
    end

    // control/status: set wins over any clear landing in the same cycle
    reg [15:0] next_csr;
    always @* begin
        next_csr = csr;
        if (csr_cmd_wr) begin
            next_csr = (csr & ~(shreg[15:0] & `DBGWR_CSR_FLAG_MASK) & ~`DBGWR_CSR_CTRL_MASK) |
                       (shreg[15:0] & `DBGWR_CSR_CTRL_MASK);
        end else if (apb_wr && paddr == `DBGWR_ADDR_CSR) begin
            next_csr = (csr & ~(pwdata[15:0] & `DBGWR_CSR_FLAG_MASK) & ~`DBGWR_CSR_CTRL_MASK) |
                       (pwdata[15:0] & `DBGWR_CSR_CTRL_MASK);
        end
        if (flash_erase_done) begin
            next_csr[`DBGWR_CSR_WIPE] = 1'b0;
        end
        if (set_no_response_flag) begin
            next_csr[`DBGWR_CSR_NO_RESPONSE_FLAG] = 1'b1;
        end
        if (set_illegal_access_flag) begin
            next_csr[`DBGWR_CSR_ILLEGAL_ACCESS_FLAG] = 1'b1;
        end
        if (set_illegal_command_flag) begin
            next_csr[`DBGWR_CSR_ILLEGAL_COMMAND_FLAG] = 1'b1;
        end
        if (set_wipe) begin
            next_csr[`DBGWR_CSR_WIPE] = 1'b1;
        end
        next_csr[`DBGWR_CSR_HALTED] = cpu_halted;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csr <= `DBGWR_CSR_RESET;
        end else begin
            csr <= next_csr;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `DBGWR_ADDR_CSR: prdata <= {16'h0000, csr};
                `DBGWR_ADDR_PC:  prdata <= {8'h00, pc_last};
                default:         prdata <= 32'h00000000;
            endcase
        end
    end

    // pc sample fails whenever the cpu cannot answer
    wire pc_timeout = cpu_in_wait || (cpu_in_stop && !csr[`DBGWR_CSR_CLKSTOP]) ||
                      external_stall_input;
    // halted or clocked stop: cpu reports the next address
    wire [23:0] pc_pick = (cpu_halted || cpu_in_stop) ? cpu_pc_next : cpu_pc_current;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state           <= ST_IDLE;
            cnt             <= 3'd0;
            shreg           <= 32'h00000000;
            pc_tx           <= 24'h000000;
            pc_last         <= 24'h000000;
            with_status     <= 1'b0;
            tx_valid        <= 1'b0;
            tx_byte         <= 8'h00;
            ack_pulse       <= 1'b0;
            soft_reset      <= 1'b0;
            mem_req         <= 1'b0;
            mem_addr        <= 24'h000000;
            mem_wdata       <= 32'h00000000;
            mem_size        <= 2'd0;
            reg_wr          <= 1'b0;
            reg_sel         <= 4'h0;
            reg_wdata       <= 32'h00000000;
            step_req        <= 1'b0;
            flash_erase_req <= 1'b0;
            wipe_armed      <= 1'b0;
            wipe_timer      <= 10'd0;
            set_no_response_flag      <= 1'b0;
            set_illegal_access_flag      <= 1'b0;
            set_illegal_command_flag      <= 1'b0;
            set_wipe        <= 1'b0;
            csr_cmd_wr      <= 1'b0;
        end else begin
            ack_pulse       <= 1'b0;
            soft_reset      <= 1'b0;
            reg_wr          <= 1'b0;
            step_req        <= 1'b0;
            flash_erase_req <= 1'b0;
            set_no_response_flag      <= 1'b0;
            set_illegal_access_flag      <= 1'b0;
            set_illegal_command_flag      <= 1'b0;
            set_wipe        <= 1'b0;
            csr_cmd_wr      <= 1'b0;
            if (tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
            end
            if (wipe_armed && dsc_tick) begin
                wipe_timer <= wipe_timer + 10'd1;
            end
            if (sync_pulse) begin
                // abort whatever is running, a pending wipe included
                soft_reset <= 1'b1;
                wipe_armed <= 1'b0;
                wipe_timer <= 10'd0;
                mem_req    <= 1'b0;
                tx_valid   <= 1'b0;
                state      <= ST_IDLE;
            end else if (wipe_armed && wipe_timer == `DBGWR_WIPE_TIMEOUT) begin
                soft_reset <= 1'b1;
                wipe_armed <= 1'b0;
                wipe_timer <= 10'd0;
                mem_req    <= 1'b0;
                tx_valid   <= 1'b0;
                state      <= ST_IDLE;
            end else begin
                case (state)
                    ST_IDLE: begin
                        // every opcode is decoded even while an erase runs
                        if (rx_take) begin
                            cnt <= 3'd0;
                            if (rx_byte != `DBGWR_OP_WIPE) begin
                                wipe_armed <= 1'b0;
                                wipe_timer <= 10'd0;
                            end
                            if (rx_byte == `DBGWR_OP_WIPE) begin
                                if (wipe_armed) begin
                                    set_wipe        <= 1'b1;
                                    flash_erase_req <= 1'b1;
                                    wipe_armed      <= 1'b0;
                                end else begin
                                    wipe_armed <= 1'b1;
                                end
                                wipe_timer <= 10'd0;
                            end else if ({rx_byte[7:4], rx_byte[1]} == 5'b00010 &&
                                         rx_byte[3:2] != 2'b11) begin
                                mem_size    <= rx_byte[3:2];
                                with_status <= rx_byte[`DBGWR_OP_WS_BIT];
                                state       <= ST_ADDR;
                            end else if (rx_byte[7:4] == `DBGWR_OP_REG_BASE) begin
                                reg_sel <= rx_byte[3:0];
                                state   <= ST_RDATA;
                            end else if (rx_byte == `DBGWR_OP_SAMPLE_PC) begin
                                pc_tx <= pc_timeout ? {3{`DBGWR_ERR_BYTE}} : pc_pick;
                                if (pc_timeout) begin
                                    set_no_response_flag <= 1'b1;
                                end else begin
                                    pc_last <= pc_pick;
                                end
                                ack_pulse <= ack_en;
                                state     <= ST_PCTX;
                            end else if (rx_byte == `DBGWR_OP_CSR_WRITE) begin
                                state <= ST_CSRD;
                            end else if (rx_byte == `DBGWR_OP_STEP) begin
                                if (cpu_halted) begin
                                    step_req <= 1'b1;
                                    state    <= ST_STEPW;
                                end
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (rx_take) begin
                            shreg <= next_shreg;
                            cnt   <= cnt + 3'd1;
                            if (cnt == 3'd2) begin
                                mem_addr <= (mem_size == 2'd2) ?
                                            {next_shreg[23:2], 2'b00} : next_shreg[23:0];
                                cnt   <= 3'd0;
                                state <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (rx_take) begin
                            shreg <= next_shreg;
                            cnt   <= cnt + 3'd1;
                            if (cnt == size_bytes(mem_size) - 3'd1) begin
                                mem_wdata <= (mem_size == 2'd0) ? {24'h000000, next_shreg[7:0]} :
                                             (mem_size == 2'd1) ? {16'h0000, next_shreg[15:0]} :
                                             next_shreg;
                                mem_req   <= 1'b1;
                                state     <= ST_MEMW;
                            end
                        end
                    end
                    ST_MEMW: begin
                        if (mem_done || mem_abort) begin
                            mem_req   <= 1'b0;
                            ack_pulse <= ack_en;
                            if (mem_abort) begin
                                set_illegal_access_flag <= 1'b1;
                            end
                            state <= with_status ? ST_STAT : ST_IDLE;
                        end
                    end
                    ST_STAT: begin
                        // next value, so an abort flag raised by this write is included
                        if (tx_free) begin
                            tx_valid <= 1'b1;
                            tx_byte  <= next_csr[7:0];
                            state    <= ST_IDLE;
                        end
                    end
                    ST_RDATA: begin
                        if (rx_take) begin
                            shreg <= next_shreg;
                            cnt   <= cnt + 3'd1;
                            if (cnt == 3'd3) begin
                                if (!cpu_halted) begin
                                    set_illegal_command_flag <= 1'b1;
                                    state      <= ST_IDLE;
                                end else if (reg_sel >= `DBGWR_CRN_BAD_FIRST) begin
                                    set_illegal_access_flag <= 1'b1;
                                    state      <= ST_IDLE;
                                end else begin
                                    reg_wdata <= next_shreg;
                                    reg_wr    <= 1'b1;
                                    state     <= ST_REGW;
                                end
                            end
                        end
                    end
                    ST_REGW: begin
                        if (reg_done) begin
                            ack_pulse <= ack_en;
                            state     <= ST_IDLE;
                        end
                    end
                    ST_PCTX: begin
                        if (tx_free) begin
                            tx_valid <= 1'b1;
                            tx_byte  <= pc_tx[23:16];
                            pc_tx    <= {pc_tx[15:0], 8'h00};
                            cnt      <= cnt + 3'd1;
                            if (cnt == 3'd2) begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_CSRD: begin
                        if (rx_take) begin
                            shreg <= next_shreg;
                            cnt   <= cnt + 3'd1;
                            if (cnt == 3'd1) begin
                                csr_cmd_wr <= 1'b1;
                                state      <= ST_IDLE;
                            end
                        end
                    end
                    ST_STEPW: begin
                        if (step_done) begin
                            ack_pulse <= ack_en;
                            state     <= ST_IDLE;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// ---- dbgwr_consts.vh ----
`ifndef DBGWR_CONSTS_VH
`define DBGWR_CONSTS_VH

// command opcodes
`define DBGWR_OP_STORE_B     8'h10
`define DBGWR_OP_STORE_W     8'h14
`define DBGWR_OP_STORE_L     8'h18
`define DBGWR_OP_WS_BIT      0
`define DBGWR_OP_REG_BASE    4'h4
`define DBGWR_OP_SAMPLE_PC   8'h01
`define DBGWR_OP_CSR_WRITE   8'h0d
`define DBGWR_OP_WIPE        8'h95
`define DBGWR_OP_STEP        8'h09

// error fill byte and invalid register selectors
`define DBGWR_ERR_BYTE       8'hee
`define DBGWR_CRN_BAD_FIRST  4'hd

// control/status register fields
`define DBGWR_CSR_NO_RESPONSE_FLAG     0
`define DBGWR_CSR_ILLEGAL_ACCESS_FLAG     1
`define DBGWR_CSR_ILLEGAL_COMMAND_FLAG     2
`define DBGWR_CSR_WIPE       3
`define DBGWR_CSR_HALTED     4
`define DBGWR_CSR_ACKEN      8
`define DBGWR_CSR_CLKSTOP    9
`define DBGWR_CSR_FLAG_MASK  16'h0007
`define DBGWR_CSR_CTRL_MASK  16'h0300
`define DBGWR_CSR_RESET      16'h0000

// apb map
`define DBGWR_ADDR_CSR       12'h000
`define DBGWR_ADDR_PC        12'h004

// timing
`define DBGWR_DSC_DIV        8'd4
`define DBGWR_WIPE_TIMEOUT   10'd512

`endif

// ---- dbgwr_core_checker.sv ----
`timescale 1ns/1ps
module dbgwr_core_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        sync_pulse,
    input wire        soft_reset,
    input wire        tx_valid,
    input wire [7:0]  tx_byte,
    input wire        tx_ready,
    input wire        ack_pulse,
    input wire        cpu_halted,
    input wire        mem_req,
    input wire [23:0] mem_addr,
    input wire [31:0] mem_wdata,
    input wire [1:0]  mem_size,
    input wire        mem_done,
    input wire        mem_abort,
    input wire        reg_wr,
    input wire [3:0]  reg_sel,
    input wire        step_req,
    input wire        flash_erase_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_lw_align: assert property (mem_req && mem_size == 2'h2 |-> mem_addr[1:0] == 2'h0)
        else $error("longword store address not aligned");
    chk_store_hold: assert property (mem_req && !mem_done && !mem_abort |=> mem_req
        && $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_size))
        else $error("store request changed before completion");
    chk_ack_late: assert property (mem_req && !mem_done && !mem_abort |=> !ack_pulse)
        else $error("acknowledge before store completed");
    chk_reg_sel: assert property (reg_wr |-> reg_sel < 4'hd)
        else $error("register write with invalid selector");
    chk_reg_halt: assert property (reg_wr |-> cpu_halted)
        else $error("register write while running");
    chk_step_halt: assert property (step_req |-> cpu_halted)
        else $error("step issued while running");
    chk_wipe_noack: assert property (flash_erase_req |-> !ack_pulse [*3])
        else $error("acknowledge after erase request");
    chk_sync_reset: assert property (sync_pulse |=> soft_reset)
        else $error("sync did not force soft reset");
    chk_tx_hold: assert property (tx_valid && !tx_ready && !sync_pulse |=> tx_valid
        && $stable(tx_byte))
        else $error("reply byte dropped before taken");
    chk_soft_pulse: assert property (soft_reset |=> !soft_reset)
        else $error("soft reset longer than one cycle");
endmodule
bind dbgwr_core dbgwr_core_checker dbgwr_core_checker_i (
    .pclk, .presetn, .sync_pulse, .soft_reset, .tx_valid, .tx_byte, .tx_ready, .ack_pulse,
    .cpu_halted, .mem_req, .mem_addr, .mem_wdata, .mem_size, .mem_done, .mem_abort,
    .reg_wr, .reg_sel, .step_req, .flash_erase_req
);

// ---- dbgwr_host_model.sv ----
`timescale 1ns/1ps
module dbgwr_host_model (
    input  wire        pclk,
    input  wire        rx_ready,
    input  wire        tx_valid,
    input  wire [7:0]  tx_byte,
    output logic       rx_valid = 1'b0,
    output logic [7:0] rx_byte = 8'h00,
    output logic       tx_ready = 1'b0,
    output logic       sync_pulse = 1'b0
);
    // bus clock is never retuned by this host
    // next byte only after the previous was taken
    task automatic send(input logic [7:0] v, output bit ok);
        ok = 0;
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_byte <= v;
        for (int i = 0; i < 200 && !ok; i++) begin
            @(posedge pclk);
            ok = rx_ready;
        end
        rx_valid <= 1'b0;
        // stale byte inverted so it never reads as fresh data
        rx_byte <= ~v;
    endtask
    task automatic recv(input int lag, output logic [7:0] v, output bit ok);
        ok = 0;
        v = 8'h00;
        repeat (lag) @(posedge pclk);
        tx_ready <= 1'b1;
        for (int i = 0; i < 5000 && !ok; i++) begin
            @(posedge pclk);
            ok = tx_valid;
            v = tx_byte;
        end
        tx_ready <= 1'b0;
    endtask
    task automatic sync();
        @(posedge pclk);
        sync_pulse <= 1'b1;
        @(posedge pclk);
        sync_pulse <= 1'b0;
    endtask
endmodule

// ---- tb_dbgwr_core.sv ----
`timescale 1ns/1ps
`include "dbgwr_consts.vh"
module tb_dbgwr_core;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        cpu_halted = 1'b0, cpu_in_wait = 1'b0, cpu_in_stop = 1'b0;
    logic        external_stall_input = 1'b0;
    logic [23:0] cpu_pc_current = 24'habcdef, cpu_pc_next = 24'h123456;
    logic        mem_done = 1'b0, mem_abort = 1'b0, reg_done = 1'b0, abort_next = 1'b0;
    logic        step_done = 1'b0, flash_erase_done = 1'b0;
    wire  [31:0] prdata, mem_wdata, reg_wdata;
    wire  [23:0] mem_addr;
    wire  [7:0]  rx_byte, tx_byte;
    wire  [3:0]  reg_sel;
    wire  [1:0]  mem_size;
    wire         pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready, ack_pulse;
    wire         sync_pulse, soft_reset, mem_req, reg_wr, step_req, flash_erase_req;
    logic [31:0] rd, lm_d, lr_d;
    logic [23:0] lm_a;
    logic [7:0]  b;
    logic [3:0]  lr_s;
    logic [1:0]  lm_s;
    logic        er;
    bit          ok;
    int          n_mismatch = 0, total_checks = 0, mw = 0, ec = 0;
    int          ev[5] = '{default: 0};
    int          s[5];
    logic [7:0]  op[3] = '{`DBGWR_OP_STORE_L, `DBGWR_OP_STORE_W | (8'h1 << `DBGWR_OP_WS_BIT),
                           `DBGWR_OP_STORE_B};
    logic [23:0] ad[3] = '{24'h123457, 24'h000003, 24'hfffffe};
    logic [31:0] wd[3] = '{32'hdeadbeef, 32'h0000a55a, 32'h0000005a};
    logic [31:0] ea[3] = '{32'h00123454, 32'h00000003, 32'h00fffffe};

    dbgwr_core dbgwr_core_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .rx_valid, .rx_byte, .rx_ready, .tx_valid, .tx_byte, .tx_ready, .ack_pulse,
        .sync_pulse, .soft_reset, .cpu_halted, .cpu_in_wait, .cpu_in_stop,
        .external_stall_input, .cpu_pc_current, .cpu_pc_next, .mem_req, .mem_addr,
        .mem_wdata, .mem_size, .mem_done, .mem_abort, .reg_wr, .reg_sel, .reg_wdata,
        .reg_done, .step_req, .step_done, .flash_erase_req, .flash_erase_done
    );
    dbgwr_host_model dbgwr_host_model_i (
        .pclk, .rx_ready, .tx_valid, .tx_byte, .rx_valid, .rx_byte, .tx_ready, .sync_pulse
    );

    always #12.5 pclk = ~pclk;

    // cpu-side responders with fixed latencies
    always @(posedge pclk) begin
        reg_done <= reg_wr;
        step_done <= step_req;
        flash_erase_done <= (ec == 1);
        ec <= flash_erase_req ? 40 : (ec > 0 ? ec - 1 : 0);
        mw <= (mem_req && !mem_done && !mem_abort) ? mw + 1 : 0;
        mem_done <= (mw == 3) && !abort_next;
        mem_abort <= (mw == 3) && abort_next;
        ev[0] <= ev[0] + ack_pulse;
        ev[1] <= ev[1] + flash_erase_req;
        ev[2] <= ev[2] + step_req;
        ev[3] <= ev[3] + reg_wr;
        ev[4] <= ev[4] + soft_reset;
        if (mem_req) begin
            lm_a <= mem_addr;
            lm_d <= mem_wdata;
            lm_s <= mem_size;
        end
        if (reg_wr) begin
            lr_s <= reg_sel;
            lr_d <= reg_wdata;
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic hang();
        n_mismatch++;
        $display("ERROR handshake expected answer seen none");
        end_sim();
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cnt(input string nm, input int k, input int d);
        chk(nm, d, ev[k] - s[k]);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        ok = 0;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge pclk);
            ok = pready;
            rd = prdata;
            er = pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) hang();
    endtask
    task automatic put(input logic [7:0] v);
        dbgwr_host_model_i.send(v, ok);
        if (!ok) hang();
    endtask
    task automatic get(input logic [7:0] e, input int lag);
        dbgwr_host_model_i.recv(lag, b, ok);
        if (!ok) hang();
        chk("reply_byte", {24'h0, e}, {24'h0, b});
    endtask
    task automatic getpc(input logic [23:0] e);
        put(`DBGWR_OP_SAMPLE_PC);
        for (int i = 2; i >= 0; i--) get(e[8*i +: 8], i + 1);
    endtask
    task automatic store(input logic [7:0] o, input logic [23:0] a, input logic [31:0] d);
        int n;
        n = o[3] ? 4 : (o[2] ? 2 : 1);
        put(o);
        for (int i = 2; i >= 0; i--) put(a[8*i +: 8]);
        for (int i = n - 1; i >= 0; i--) put(d[8*i +: 8]);
    endtask
    task automatic regst(input logic [3:0] sel, input logic [31:0] d);
        put({`DBGWR_OP_REG_BASE, sel});
        for (int i = 3; i >= 0; i--) put(d[8*i +: 8]);
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `DBGWR_ADDR_CSR, 32'h0);
        chk("csr_reset", {16'h0, `DBGWR_CSR_RESET}, rd);
        apb(1'b0, 12'h0f0, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        apb(1'b1, `DBGWR_ADDR_CSR, 32'h100);
        for (int k = 0; k < 3; k++) begin
            s = ev;
            abort_next = (k == 1);
            store(op[k], ad[k], wd[k]);
            if (k == 1) get(8'h1 << `DBGWR_CSR_ILLEGAL_ACCESS_FLAG, 2);
            tick(8);
            chk("store_addr", ea[k], {8'h0, lm_a});
            chk("store_data", wd[k], lm_d);
            chk("store_size", 2 - k, {30'h0, lm_s});
            cnt("store_ack", 0, 1);
        end
        apb(1'b1, `DBGWR_ADDR_CSR, 32'h107);
        getpc(cpu_pc_current);
        apb(1'b0, `DBGWR_ADDR_PC, 32'h0);
        chk("pc_last", {8'h0, cpu_pc_current}, rd);
        cpu_halted <= 1'b1;
        getpc(cpu_pc_next);
        cpu_halted <= 1'b0;
        cpu_in_stop <= 1'b1;
        apb(1'b1, `DBGWR_ADDR_CSR, 32'h300);
        getpc(cpu_pc_next);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, `DBGWR_ADDR_CSR, 32'h107);
            cpu_in_wait <= (k == 0);
            cpu_in_stop <= (k == 1);
            external_stall_input <= (k == 2);
            getpc({3{`DBGWR_ERR_BYTE}});
            apb(1'b0, `DBGWR_ADDR_CSR, 32'h0);
            chk("no_response", 32'h1, {31'h0, rd[`DBGWR_CSR_NO_RESPONSE_FLAG]});
        end
        external_stall_input <= 1'b0;
        apb(1'b1, `DBGWR_ADDR_CSR, 32'h107);
        s = ev;
        regst(4'hc, 32'h89abcdef);
        tick(6);
        cnt("reg_write", 3, 0);
        apb(1'b0, `DBGWR_ADDR_CSR, 32'h0);
        chk("illegal_cmd", 32'h1, {31'h0, rd[`DBGWR_CSR_ILLEGAL_COMMAND_FLAG]});
        cpu_halted <= 1'b1;
        s = ev;
        regst(4'hc, 32'h89abcdef);
        tick(6);
        chk("reg_value", 32'h89abcdef, lr_d);
        chk("reg_sel", 32'hc, {28'h0, lr_s});
        cnt("reg_ack", 0, 1);
        regst(4'he, 32'h1);
        tick(6);
        cnt("reg_write", 3, 1);
        apb(1'b0, `DBGWR_ADDR_CSR, 32'h0);
        chk("illegal_acc", 32'h1, {31'h0, rd[`DBGWR_CSR_ILLEGAL_ACCESS_FLAG]});
        s = ev;
        put(`DBGWR_OP_STEP);
        tick(6);
        cnt("step", 2, 1);
        cnt("step_ack", 0, 1);
        cpu_halted <= 1'b0;
        put(`DBGWR_OP_STEP);
        tick(6);
        cnt("step", 2, 1);
        s = ev;
        put(`DBGWR_OP_CSR_WRITE);
        put(8'h03);
        put(8'h06);
        tick(4);
        apb(1'b0, `DBGWR_ADDR_CSR, 32'h0);
        chk("csr_link", 32'h300, {16'h0, rd[15:0]});
        cnt("csr_ack", 0, 0);
        s = ev;
        put(`DBGWR_OP_WIPE);
        put(`DBGWR_OP_WIPE);
        tick(3);
        cnt("erase_req", 1, 1);
        cnt("wipe_ack", 0, 0);
        apb(1'b0, `DBGWR_ADDR_CSR, 32'h0);
        chk("wipe_busy", 32'h1, {31'h0, rd[`DBGWR_CSR_WIPE]});
        for (int i = 0; i < 40 && rd[`DBGWR_CSR_WIPE] !== 1'b0; i++)
            apb(1'b0, `DBGWR_ADDR_CSR, 32'h0);
        chk("wipe_done", 32'h0, {31'h0, rd[`DBGWR_CSR_WIPE]});
        put(`DBGWR_OP_WIPE);
        put(`DBGWR_OP_STEP);
        put(`DBGWR_OP_WIPE);
        tick(4);
        cnt("erase_req", 1, 1);
        tick(int'(`DBGWR_DSC_DIV) * int'(`DBGWR_WIPE_TIMEOUT) - 16);
        cnt("soft_reset", 4, 0);
        tick(32);
        cnt("soft_reset", 4, 1);
        put(`DBGWR_OP_WIPE);
        dbgwr_host_model_i.sync();
        tick(3);
        cnt("soft_reset", 4, 2);
        put(`DBGWR_OP_WIPE);
        tick(4);
        cnt("erase_req", 1, 1);
        end_sim();
    end
endmodule
